// *** sim/lp_cal_props.sv ***
// Purpose: port checks for the cal/trim bank
// Assumes: one clock, nrst low resets
// Notes: bound onto every instance
`timescale 1ns/1ps
module lp_cal_props
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic cal_done,
  input wire logic converter_sleep,
  input wire logic cal_start,
  input wire logic [7:0] core_gain_adjust_out,
  input wire logic [3:0] bandgap_adjust_out,
  input wire logic [7:0] termination_adjust_a_out,
  input wire logic [7:0] termination_adjust_b_out
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_rdata_one_cycle: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_gain_readback: assert property (rd_en && addr == 8'h7A
    |=> rdata == $past(core_gain_adjust_out))
    else $error("gain read mismatch");
  a_bandgap_write: assert property (wr_en && addr == 8'h7C
    |=> bandgap_adjust_out == $past(wdata[3:0]))
    else $error("bandgap write lost");
  a_term_a_write: assert property (wr_en && addr == 8'h7E
    |=> termination_adjust_a_out == $past(wdata))
    else $error("term a write lost");
  a_term_b_write: assert property (wr_en && addr == 8'h7F
    |=> termination_adjust_b_out == $past(wdata))
    else $error("term b write lost");
  a_sleep_cal_apart: assert property (!(converter_sleep && cal_start))
    else $error("sleep and cal together");
  a_settle_first: assert property ($fell(converter_sleep) |-> !cal_start [*8])
    else $error("cal without settling");
  a_cal_holds: assert property (cal_start && !cal_done && !wr_en && !$past(wr_en)
    |=> cal_start)
    else $error("cal dropped early");
  a_done_to_sleep: assert property (cal_start && cal_done && !$past(wr_en)
    |=> converter_sleep)
    else $error("no sleep after cal");
endmodule // lp_cal_props
bind lowpower_cal_and_trim_regs lp_cal_props u_props (.core_clk, .nrst, .addr, .wdata, .wr_en,
  .rd_en, .rdata, .cal_done, .converter_sleep, .cal_start, .core_gain_adjust_out,
  .bandgap_adjust_out, .termination_adjust_a_out, .termination_adjust_b_out);

// *** sim/tb_lowpower_cal_and_trim_regs.sv ***
// Purpose: self-checking bench for the cal/trim bank
// Assumes: sleep and wake code 0 give 1152 cycles
// Notes: long codes are left to the table of constants
`timescale 1ns/1ps
module tb_lowpower_cal_and_trim_regs;
  logic core_clk = 0;
  logic nrst = 0;
  logic wr_en = 0;
  logic rd_en = 0;
  logic pin = 0;
  logic done = 0;
  logic [7:0] addr = 0;
  logic [7:0] wdata = 0;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [3:0] bg;
  logic [7:0] fg = 8'h5A;
  logic [7:0] gout;
  logic [7:0] tbo;
  logic slp;
  logic cst;
  int n_fail = 0;
  int comparisons = 0;
  int n;
  // addr, write data, expected read back
  // reserved bits written as zero, as software must
  logic [23:0] rows [7] = '{24'h7A_A5A5, 24'h7C_0F0F, 24'h7E_5A5A, 24'h7F_0101,
    24'h6E_FBFB, 24'hF1_FF00, 24'h00_5500};
  always #5 core_clk = ~core_clk;
  lowpower_cal_and_trim_regs dut (.core_clk(core_clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cal_trigger_pin(pin),
    .fuse_gain(fg), .fuse_bandgap(8'hE7), .fuse_term_a(8'h3C), .fuse_term_b(8'hC3),
    .cal_done(done), .converter_sleep(slp), .cal_start(cst), .core_gain_adjust_out(gout),
    .bandgap_adjust_out(bg), .termination_adjust_a_out(), .termination_adjust_b_out(tbo));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    wr_en <= 1;
    addr <= a;
    wdata <= v;
    @(posedge core_clk);
    wr_en <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    rd_en <= 1;
    addr <= a;
    @(posedge core_clk);
    rd_en <= 0;
    #1;
    d = rdata;
  endtask
  // counts edges until the sleep or cal line reaches lvl
  task automatic cnt(input bit sel, input logic lvl);
    n = 0;
    while (((sel ? cst : slp) !== lvl) && n < 3000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 3000)
    begin
      n_fail++;
      end_sim;
    end
  endtask
  task automatic pulse_done;
    @(posedge core_clk);
    done <= 1;
    @(posedge core_clk);
    done <= 0;
    #1;
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    nrst <= 1;
    repeat (4) @(posedge core_clk);
    rd(8'h6E);
    check("ctrl_reset", d, 8'h88);
    rd(8'h7A);
    check("gain_fuse", d, 8'h5A);
    rd(8'h7C);
    check("bg_fuse", d, 8'h07);
    check("bg_out", bg, 4'h7);
    rd(8'h7E);
    check("term_a_fuse", d, 8'h3C);
    rd(8'h7F);
    check("term_b_fuse", d, 8'hC3);
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      check("row_read", d, rows[i][7:0]);
    end
    check("gain_out", gout, 8'hA5);
    check("term_b_out", tbo, 8'h01);
    // -------------------------------
    // timed sleep, settle, cal loop
    // -------------------------------
    // codes 0 only to keep the run short; mode last so sleep starts fresh
    wr(8'h6E, 8'h01);
    wr(8'hF0, 8'h02);
    cnt(0, 1);
    cnt(0, 0);
    check("sleep_len", n, 1152);
    cnt(1, 1);
    check("settle_len", n, 1152);
    pulse_done;
    check("resleep", slp, 1);
    // -------------------------------
    // trigger paced, soft then pin
    // -------------------------------
    wr(8'h6E, 8'h03);
    repeat (1300) @(posedge core_clk);
    #1;
    check("paced_hold", slp, 1);
    rd(8'hF1);
    check("sleep_state", d, 8'h01);
    wr(8'h6C, 8'h00);
    cnt(0, 0);
    check("soft_wake", n <= 3, 1);
    cnt(1, 1);
    @(posedge core_clk);
    pin <= 1;
    wr(8'hF0, 8'h03);
    pulse_done;
    repeat (40) @(posedge core_clk);
    #1;
    check("pin_hold", slp, 1);
    @(posedge core_clk);
    pin <= 0;
    cnt(0, 0);
    check("pin_wake", n <= 5, 1);
    wr(8'hF0, 8'h00);
    repeat (3) @(posedge core_clk);
    rd(8'hF1);
    check("idle_state", d, 8'h00);
    check("idle_lines", {slp, cst}, 2'b00);
    // -------------------------------
    // mid-run reset with a new fuse value
    // -------------------------------
    wr(8'h7A, 8'h11);
    wr(8'hF0, 8'h02);
    @(posedge core_clk);
    nrst <= 0;
    fg <= 8'h96;
    repeat (3) @(posedge core_clk);
    nrst <= 1;
    repeat (4) @(posedge core_clk);
    rd(8'h7A);
    check("gain_refuse", d, 8'h96);
    check("gain_out_fuse", gout, 8'h96);
    rd(8'h6E);
    check("ctrl_rereset", d, 8'h88);
    check("reset_lines", {slp, cst}, 2'b00);
    // reset sleep and wake codes: far longer than the run
    wr(8'hF0, 8'h02);
    wr(8'h6E, 8'h89);
    repeat (3000) @(posedge core_clk);
    #1;
    check("code4_sleep", slp, 1);
    end_sim;
  end
endmodule // tb_lowpower_cal_and_trim_regs

// *** verilog/lowpower_cal_and_trim_regs.sv ***
// Purpose: low-power background calibration pacing and trim register bank
// Assumes: core_clk is the sample clock; fuse values are stable during reset
// Notes: one offline converter is paced; cal engine handshakes via cal_start/cal_done
//
// Behaviour
// RQ1 - Sleep codes 0, 3 and 4 give 1152, 268435584 and 2147483776 periods, code 4 at reset.
// RQ2 - Sleep codes 6 and 7 give 137438953600 and 1099511627904 periods.
// RQ3 - Sleep codes 1, 2 and 5 give 4194432, 33554560 and 17179869312 periods.
// RQ4 - Software keeps sleep codes at 4 or above; the field only acts when enabled.
// RQ5 - Wake codes 0 to 3 give 1152, 33554560, 268435584 and 2147483776 settle periods.
// RQ6 - Software avoids wake code 0; settling only acts when enabled.
// RQ7 - With trigger pacing off the sleep is timed from the sleep field.
// RQ8 - With trigger pacing on the converter sleeps while the trigger is high.
// RQ9 - Low-power calibration runs only with enable and background mode both set.
// RQ10 - Software writes reserved bits with their reset value.
// RQ11 - Gain trim moves all cores together; range changes use the range setting.
// RQ12 - A 4-bit band-gap trim in bits 3:0 reads its fuse value after reset.
// RQ13 - Termination trims for inputs A and B read their fuse values after reset.
// RQ14 - Trim registers load from fuse storage after reset.
// RQ15 - The trigger comes from the pin or the soft bit per the source select.
// RQ16 - The control register resets to 0x88.
`timescale 1ns/1ps
module lowpower_cal_and_trim_regs
#(
  parameter int count_width = lp_cal_pkg::count_width
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic cal_trigger_pin,
  input wire logic [7:0] fuse_gain,
  input wire logic [7:0] fuse_bandgap,
  input wire logic [7:0] fuse_term_a,
  input wire logic [7:0] fuse_term_b,
  input wire logic cal_done,
  output logic converter_sleep,
  output logic cal_start,
  output logic [7:0] core_gain_adjust_out,
  output logic [3:0] bandgap_adjust_out,
  output logic [7:0] termination_adjust_a_out,
  output logic [7:0] termination_adjust_b_out
);
  // ----------------------------------------
  // reset release and pin synchroniser
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;
  logic trig_meta;
  logic trig_sync;
  logic fuse_pending;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
    end
    else
    begin
      trig_meta <= cal_trigger_pin;
      trig_sync <= trig_meta;
    end
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // one strobe decode shared by the control, soft trigger and trigger config registers
  function automatic logic wr_hit(input logic [7:0] offset);
    wr_hit = wr_en && (addr == offset);
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] lowpower_cal_control;
  logic [7:0] core_gain_adjust;
  logic [7:0] bandgap_adjust;
  logic [7:0] termination_adjust_a;
  logic [7:0] termination_adjust_b;
  logic [7:0] soft_trig;
  logic [7:0] trig_cfg;
  lp_cal_pkg::lp_state_type state;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      lowpower_cal_control <= lp_cal_pkg::lowpower_cal_control_reset; // [RQ16]
    else if (wr_hit(lp_cal_pkg::lowpower_cal_control_offset))
      lowpower_cal_control <= wdata & lp_cal_pkg::lp_control_rw_mask;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      soft_trig <= lp_cal_pkg::soft_trig_reset;
    else if (wr_hit(lp_cal_pkg::soft_trig_offset))
      soft_trig <= wdata & lp_cal_pkg::soft_trig_mask; // [RQ15]
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      trig_cfg <= lp_cal_pkg::trig_cfg_reset;
    else if (wr_hit(lp_cal_pkg::trig_cfg_offset))
      trig_cfg <= wdata & lp_cal_pkg::trig_cfg_mask; // [RQ9]
  end

  // fuses are sampled one clock after release, never inside the async reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      fuse_pending <= 1'b1;
    else
      fuse_pending <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_gain_adjust <= 8'h00;
      bandgap_adjust <= 8'h00;
      termination_adjust_a <= 8'h00;
      termination_adjust_b <= 8'h00;
    end
    else if (fuse_pending)
    begin
      core_gain_adjust <= fuse_gain; // [RQ14]
      bandgap_adjust <= fuse_bandgap & lp_cal_pkg::bandgap_mask; // [RQ12]
      termination_adjust_a <= fuse_term_a; // [RQ13]
      termination_adjust_b <= fuse_term_b; // [RQ13]
    end
    else if (wr_en)
    begin
      if (addr == lp_cal_pkg::core_gain_adjust_offset)
        core_gain_adjust <= wdata; // [RQ11]
      else if (addr == lp_cal_pkg::bandgap_adjust_offset)
        bandgap_adjust <= wdata & lp_cal_pkg::bandgap_mask; // [RQ12]
      else if (addr == lp_cal_pkg::termination_adjust_a_offset)
        termination_adjust_a <= wdata; // [RQ13]
      else if (addr == lp_cal_pkg::termination_adjust_b_offset)
        termination_adjust_b <= wdata; // [RQ13]
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    // zero between reads, so a stale byte never passes for a fresh one
    else if (!rd_en)
      rdata <= 8'h00;
    else if (addr == lp_cal_pkg::lowpower_cal_control_offset)
      rdata <= lowpower_cal_control;
    else if (addr == lp_cal_pkg::core_gain_adjust_offset)
      rdata <= core_gain_adjust;
    else if (addr == lp_cal_pkg::bandgap_adjust_offset)
      rdata <= bandgap_adjust;
    else if (addr == lp_cal_pkg::termination_adjust_a_offset)
      rdata <= termination_adjust_a;
    else if (addr == lp_cal_pkg::termination_adjust_b_offset)
      rdata <= termination_adjust_b;
    else if (addr == lp_cal_pkg::soft_trig_offset)
      rdata <= soft_trig;
    else if (addr == lp_cal_pkg::trig_cfg_offset)
      rdata <= trig_cfg;
    else if (addr == lp_cal_pkg::lp_status_offset)
      rdata <= {6'h00, state};
    else
      rdata <= 8'h00;
  end

  // ----------------------------------------
  // interval decoding
  // ----------------------------------------
  function automatic logic [40:0] sleep_len(input logic [2:0] code);
    case (code)
      3'h0: sleep_len = lp_cal_pkg::period_1152; // [RQ1]
      3'h1: sleep_len = lp_cal_pkg::period_4194432; // [RQ3]
      3'h2: sleep_len = lp_cal_pkg::period_33554560; // [RQ3]
      3'h3: sleep_len = lp_cal_pkg::period_268435584; // [RQ1]
      3'h4: sleep_len = lp_cal_pkg::period_2147483776; // [RQ1]
      3'h5: sleep_len = lp_cal_pkg::period_17179869312; // [RQ3]
      3'h6: sleep_len = lp_cal_pkg::period_137438953600; // [RQ2]
      default: sleep_len = lp_cal_pkg::period_1099511627904; // [RQ2]
    endcase
  endfunction

  function automatic logic [40:0] wake_len(input logic [1:0] code);
    case (code)
      2'h0: wake_len = lp_cal_pkg::period_1152; // [RQ5]
      2'h1: wake_len = lp_cal_pkg::period_33554560; // [RQ5]
      2'h2: wake_len = lp_cal_pkg::period_268435584; // [RQ5]
      default: wake_len = lp_cal_pkg::period_2147483776; // [RQ5]
    endcase
  endfunction

  // ----------------------------------------
  // sleep / settle sequencer
  // ----------------------------------------
  logic active;
  logic paced;
  logic cal_trigger;
  logic [count_width-1:0] timer;
  logic [40:0] sleep_target;
  logic [40:0] wake_target;

  // the pin is already two flops deep, so both sources look alike here
  assign cal_trigger = trig_cfg[lp_cal_pkg::trig_src_bit] ? trig_sync // [RQ15]
                       : soft_trig[lp_cal_pkg::soft_trig_bit];
  assign active = lowpower_cal_control[lp_cal_pkg::enable_bit] // [RQ9]
                  & trig_cfg[lp_cal_pkg::bg_mode_bit];
  assign paced = lowpower_cal_control[lp_cal_pkg::trig_paced_bit]; // [RQ8]
  assign sleep_target =
    sleep_len(lowpower_cal_control[lp_cal_pkg::sleep_msb:lp_cal_pkg::sleep_lsb]); // [RQ7]
  assign wake_target =
    wake_len(lowpower_cal_control[lp_cal_pkg::wake_msb:lp_cal_pkg::wake_lsb]); // [RQ5]

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= lp_cal_pkg::st_idle;
      timer <= '0;
    end
    // dropping enable or mode parks the sequencer with the converter awake
    else if (!active)
    begin
      state <= lp_cal_pkg::st_idle; // [RQ9]
      timer <= '0;
    end
    else
    begin
      case (state)
        lp_cal_pkg::st_idle:
        begin
          state <= lp_cal_pkg::st_sleep;
          timer <= '0;
        end
        lp_cal_pkg::st_sleep:
        begin
          if (paced)
          begin
            // parked, so a later switch to timed mode counts from zero
            timer <= '0;
            if (!cal_trigger)
              state <= lp_cal_pkg::st_settle; // [RQ8]
          end
          else if (41'(timer) + 41'h1 >= sleep_target)
          begin
            state <= lp_cal_pkg::st_settle; // [RQ7]
            timer <= '0;
          end
          else
            timer <= timer + 1'b1; // [RQ7]
        end
        lp_cal_pkg::st_settle:
        begin
          if (41'(timer) + 41'h1 >= wake_target)
          begin
            state <= lp_cal_pkg::st_cal; // [RQ5]
            timer <= '0;
          end
          else
            timer <= timer + 1'b1;
        end
        default:
        begin
          timer <= '0;
          if (cal_done)
            state <= lp_cal_pkg::st_sleep;
        end
      endcase
    end
  end

  assign converter_sleep = (state == lp_cal_pkg::st_sleep); // [RQ8]
  assign cal_start = (state == lp_cal_pkg::st_cal);
  assign core_gain_adjust_out = core_gain_adjust;
  assign bandgap_adjust_out = bandgap_adjust[3:0];
  assign termination_adjust_a_out = termination_adjust_a;
  assign termination_adjust_b_out = termination_adjust_b;
endmodule // lowpower_cal_and_trim_regs

// *** verilog/lp_cal_pkg.sv ***
// Purpose: constants for the low-power calibration and trim register bank
// Assumes: 8-bit register port, byte offsets as printed
// Notes: sleep and wake counts are in sample clock periods
package lp_cal_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] soft_trig_offset = 8'h6C;
  localparam logic [7:0] lowpower_cal_control_offset = 8'h6E;
  localparam logic [7:0] core_gain_adjust_offset = 8'h7A;
  localparam logic [7:0] bandgap_adjust_offset = 8'h7C;
  localparam logic [7:0] termination_adjust_a_offset = 8'h7E;
  localparam logic [7:0] termination_adjust_b_offset = 8'h7F;
  localparam logic [7:0] trig_cfg_offset = 8'hF0;
  localparam logic [7:0] lp_status_offset = 8'hF1;
  // ----------------------------------------
  // reset values and fields
  // ----------------------------------------
  localparam logic [7:0] lowpower_cal_control_reset = 8'h88;
  localparam logic [7:0] soft_trig_reset = 8'h01;
  localparam logic [7:0] trig_cfg_reset = 8'h00;
  localparam int sleep_msb = 7;
  localparam int sleep_lsb = 5;
  localparam int wake_msb = 4;
  localparam int wake_lsb = 3;
  localparam int trig_paced_bit = 1;
  localparam int enable_bit = 0;
  localparam int bg_mode_bit = 1;
  localparam int trig_src_bit = 0;
  localparam int soft_trig_bit = 0;
  localparam logic [7:0] lp_control_rw_mask = 8'hFB;
  localparam logic [7:0] bandgap_mask = 8'h0F;
  localparam logic [7:0] soft_trig_mask = 8'h01;
  localparam logic [7:0] trig_cfg_mask = 8'h03;
  localparam int count_width = 41;
  // ----------------------------------------
  // sleep and settle lengths, sample clock periods
  // ----------------------------------------
  localparam logic [40:0] period_1152 = 41'h000_0000_0480;
  localparam logic [40:0] period_4194432 = 41'h000_0040_0080;
  localparam logic [40:0] period_33554560 = 41'h000_0200_0080;
  localparam logic [40:0] period_268435584 = 41'h000_1000_0080;
  localparam logic [40:0] period_2147483776 = 41'h000_8000_0080;
  localparam logic [40:0] period_17179869312 = 41'h004_0000_0080;
  localparam logic [40:0] period_137438953600 = 41'h020_0000_0080;
  localparam logic [40:0] period_1099511627904 = 41'h100_0000_0080;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_sleep = 2'b01,
    st_settle = 2'b10,
    st_cal = 2'b11
  } lp_state_type;
endpackage
